//--- shared/hfpa_pkg.sv
package hfpa_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 3;
  localparam int DROP_W = 8;
  localparam int KEEP_W = 16;

  // ----------------------------------------------------------------
  // Port and register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_DATA = 8'h00;
  localparam logic [7:0] ADDR_TX_DATA = 8'h20;
  localparam logic [7:0] ALIAS_MASK = 8'he0;
  localparam logic [7:0] WORD_MASK = 8'hfc;
  localparam logic [7:0] ADDR_RX_STAT_POP = 8'h40;
  localparam logic [7:0] ADDR_RX_STAT_PEEK = 8'h44;
  localparam logic [7:0] ADDR_TX_STAT_POP = 8'h48;
  localparam logic [7:0] ADDR_TX_STAT_PEEK = 8'h4c;
  localparam logic [7:0] ADDR_STATUS = 8'h50;
  localparam logic [7:0] ADDR_CTRL = 8'h54;
  localparam logic [7:0] ADDR_EVENT = 8'h58;
  localparam logic [7:0] ADDR_LATCH = 8'h5c;
  localparam logic [7:0] ADDR_DROP = 8'h60;
  localparam logic [7:0] ADDR_KEEP = 8'h64;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RX_FLUSH = 0;
  localparam int CTRL_TX_FLUSH = 1;
  localparam int CTRL_SOFT_RST = 2;
  localparam int CTRL_RXD_CAP_LSB = 8;
  localparam int CTRL_RXS_CAP_LSB = 12;
  localparam int CTRL_TXD_CAP_LSB = 16;
  localparam int STAT_RXS_LVL_LSB = 0;
  localparam int STAT_RXD_LVL_LSB = 4;
  localparam int STAT_TXS_LVL_LSB = 8;
  localparam int STAT_TXD_LVL_LSB = 12;
  localparam int STAT_MODE16 = 16;
  localparam int EVT_RXD_UNDER = 0;
  localparam int EVT_TXD_OVER = 1;
  localparam int EVT_RXS_UNDER = 2;
  localparam int EVT_TXS_UNDER = 3;
  localparam int EVT_N = 4;
  localparam int LATCH_RXD_FULL = 0;
  localparam int LATCH_TXD_ROOM = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CAP_RESET = 3'h4;
  localparam logic [KEEP_W-1:0] KEEP_RESET = 16'h0000;
  localparam logic [DROP_W-1:0] DROP_RESET = 8'h00;
  localparam logic [DROP_W-1:0] DROP_MAX = 8'hff;
endpackage : hfpa_pkg

//--- src/hfpa_fifo.sv
module hfpa_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int CW = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic flush,
  input wire logic [CW-1:0] cap,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [CW-1:0] level
);
  // ----------------------------------------------------------------
  // Storage, pointers wrap at DEPTH
  // ----------------------------------------------------------------
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);
  wire [AW-1:0] next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
  wire next_ready = (next_count < cap) && (next_count < CW'(DEPTH));

  assign out_data = mem[rd_ptr];
  assign level = count;

  always_ff @(posedge clk) begin
    if (reset || flush) begin
      count <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      wr_ptr <= push ? next_wr_ptr : wr_ptr;
      rd_ptr <= pop ? next_rd_ptr : rd_ptr;
      in_ready <= next_ready;
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : hfpa_fifo

//--- src/hfpa_w1c_bank.sv
module hfpa_w1c_bank #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [N-1:0] set,
  input wire logic clr_wr,
  input wire logic [N-1:0] clr_data,
  output logic [N-1:0] bits
);
  // ----------------------------------------------------------------
  // Sticky bits, a new event wins over a clear
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      wire next_bit = set[i] | (bits[i] & ~(clr_wr & clr_data[i]));
      always_ff @(posedge clk) begin
        if (reset) begin
          bits[i] <= 1'b0;
        end else begin
          bits[i] <= next_bit;
        end
      end
    end
  endgenerate
endmodule : hfpa_w1c_bank

//--- src/hfpa_host_port.sv
// Overview of operation
// - Writes to read-only registers change nothing
// - Write-only port reads return zero
// - Writing one clears bit, zero keeps it
// - Read returns value, then bit clears
// - Latched status holds until its register read
// - Immune bits survive software reset
// - Every reset loads register defaults, except keep on soft reset
// - Four FIFOs, three with configurable sizes
// - Receive status pop read removes head
// - Receive status peek leaves FIFO unchanged
// - Receive data reads pop, aliased window
// - Transmit status pop read removes head
// - Transmit status peek leaves FIFO unchanged
// - Transmit data write-only, aliased push window
// - Writes to receive ports change nothing
module hfpa_host_port import hfpa_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_mode16_strap,
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [DATA_W-1:0] host_wdata,
  output logic [DATA_W-1:0] host_rdata,
  output logic host_rvalid,
  input wire logic [DATA_W-1:0] rx_stat_in,
  input wire logic rx_stat_in_valid,
  output logic rx_stat_in_ready,
  input wire logic [DATA_W-1:0] rx_data_in,
  input wire logic rx_data_in_valid,
  output logic rx_data_in_ready,
  input wire logic [DATA_W-1:0] tx_stat_in,
  input wire logic tx_stat_in_valid,
  output logic tx_stat_in_ready,
  output logic [DATA_W-1:0] tx_data_out,
  output logic tx_data_out_valid,
  input wire logic tx_data_out_ready
);
  // ----------------------------------------------------------------
  // Bus mode and resets
  // ----------------------------------------------------------------
  logic mode16;
  logic soft_rst;
  wire sreset = reset | soft_rst;

  always_ff @(posedge clk) begin
    if (reset) begin
      mode16 <= bus_mode16_strap;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire rd_acc = host_cs & host_rd;
  wire wr_acc = host_cs & host_wr & ~host_rd;
  wire [7:0] word_addr = host_addr & WORD_MASK;
  wire in_rxd = (host_addr & ALIAS_MASK) == ADDR_RX_DATA;
  wire in_txd = (host_addr & ALIAS_MASK) == ADDR_TX_DATA;
  wire hit_rxs_pop = word_addr == ADDR_RX_STAT_POP;
  wire hit_rxs_peek = word_addr == ADDR_RX_STAT_PEEK;
  wire hit_txs_pop = word_addr == ADDR_TX_STAT_POP;
  wire hit_txs_peek = word_addr == ADDR_TX_STAT_PEEK;
  wire ctrl_wr = wr_acc & (word_addr == ADDR_CTRL);
  wire ev_clr_wr = wr_acc & (word_addr == ADDR_EVENT);
  wire keep_wr = wr_acc & (word_addr == ADDR_KEEP);
  wire latch_rd = rd_acc & (word_addr == ADDR_LATCH);
  wire drop_rd = rd_acc & (word_addr == ADDR_DROP);
  wire hi_half = ~mode16 | host_addr[1];

  // ----------------------------------------------------------------
  // FIFO side signals
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rxs_data;
  logic [DATA_W-1:0] rxd_data;
  logic [DATA_W-1:0] txs_data;
  logic rxs_valid;
  logic rxd_valid;
  logic txs_valid;
  logic txd_ready;
  logic [CNT_W-1:0] rxs_level;
  logic [CNT_W-1:0] rxd_level;
  logic [CNT_W-1:0] txs_level;
  logic [CNT_W-1:0] txd_level;
  logic [CNT_W-1:0] rxd_cap;
  logic [CNT_W-1:0] rxs_cap;
  logic [CNT_W-1:0] txd_cap;
  logic rx_flush;
  logic tx_flush;
  logic rxd_half;
  logic txd_half;
  logic [HALF_W-1:0] txd_low;

  wire rxd_rd = rd_acc & in_rxd;
  wire rxd_pop = rxd_rd & rxd_valid & (~mode16 | rxd_half);
  wire rxs_pop = rd_acc & hit_rxs_pop & rxs_valid & hi_half;
  wire txs_pop = rd_acc & hit_txs_pop & txs_valid & hi_half;
  wire txd_wr = wr_acc & in_txd;
  wire txd_push = txd_wr & (~mode16 | txd_half);
  wire [DATA_W-1:0] txd_word = mode16 ? {host_wdata[HALF_W-1:0], txd_low} : host_wdata;
  wire rxs_push = rx_stat_in_valid & rx_stat_in_ready;
  wire rxd_push = rx_data_in_valid & rx_data_in_ready;
  wire txs_push = tx_stat_in_valid & tx_stat_in_ready;
  wire txd_drain = tx_data_out_valid & tx_data_out_ready;
  wire refused = (rx_data_in_valid & ~rx_data_in_ready) | (rx_stat_in_valid & ~rx_stat_in_ready);

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  hfpa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_rx_stat (
    .clk(clk), .reset(sreset), .flush(rx_flush), .cap(rxs_cap),
    .in_data(rx_stat_in), .in_valid(rx_stat_in_valid), .in_ready(rx_stat_in_ready),
    .out_data(rxs_data), .out_valid(rxs_valid), .out_ready(rxs_pop), .level(rxs_level)
  );
  hfpa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_rx_data (
    .clk(clk), .reset(sreset), .flush(rx_flush), .cap(rxd_cap),
    .in_data(rx_data_in), .in_valid(rx_data_in_valid), .in_ready(rx_data_in_ready),
    .out_data(rxd_data), .out_valid(rxd_valid), .out_ready(rxd_pop), .level(rxd_level)
  );
  hfpa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_tx_stat (
    .clk(clk), .reset(sreset), .flush(tx_flush), .cap(CNT_W'(FIFO_DEPTH)),
    .in_data(tx_stat_in), .in_valid(tx_stat_in_valid), .in_ready(tx_stat_in_ready),
    .out_data(txs_data), .out_valid(txs_valid), .out_ready(txs_pop), .level(txs_level)
  );
  hfpa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_tx_data (
    .clk(clk), .reset(sreset), .flush(tx_flush), .cap(txd_cap),
    .in_data(txd_word), .in_valid(txd_push), .in_ready(txd_ready),
    .out_data(tx_data_out), .out_valid(tx_data_out_valid), .out_ready(tx_data_out_ready),
    .level(txd_level)
  );

  // ----------------------------------------------------------------
  // Half-word pairing in 16-bit mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sreset || rx_flush) begin
      rxd_half <= 1'b0;
    end else if (mode16 && rxd_rd && rxd_valid) begin
      rxd_half <= ~rxd_half;
    end
  end

  always_ff @(posedge clk) begin
    if (sreset || tx_flush) begin
      txd_half <= 1'b0;
      txd_low <= '0;
    end else if (mode16 && txd_wr) begin
      txd_half <= ~txd_half;
      txd_low <= txd_half ? txd_low : host_wdata[HALF_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Control register, self-clearing actions
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sreset) begin
      rxd_cap <= CAP_RESET;
      rxs_cap <= CAP_RESET;
      txd_cap <= CAP_RESET;
      rx_flush <= 1'b0;
      tx_flush <= 1'b0;
    end else begin
      rxd_cap <= ctrl_wr ? host_wdata[CTRL_RXD_CAP_LSB +: CNT_W] : rxd_cap;
      rxs_cap <= ctrl_wr ? host_wdata[CTRL_RXS_CAP_LSB +: CNT_W] : rxs_cap;
      txd_cap <= ctrl_wr ? host_wdata[CTRL_TXD_CAP_LSB +: CNT_W] : txd_cap;
      rx_flush <= ctrl_wr & host_wdata[CTRL_RX_FLUSH];
      tx_flush <= ctrl_wr & host_wdata[CTRL_TX_FLUSH];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= ctrl_wr & host_wdata[CTRL_SOFT_RST] & ~soft_rst;
    end
  end

  // ----------------------------------------------------------------
  // Status bits: sticky events, latches, drop counter, immune word
  // ----------------------------------------------------------------
  logic [EVT_N-1:0] events;
  logic [EVT_N-1:0] ev_set;
  logic lat_full;
  logic lat_room;
  logic [DROP_W-1:0] drop;
  logic [KEEP_W-1:0] keep;

  assign ev_set[EVT_RXD_UNDER] = rxd_rd & ~rxd_valid;
  assign ev_set[EVT_TXD_OVER] = txd_push & ~txd_ready;
  assign ev_set[EVT_RXS_UNDER] = rd_acc & hit_rxs_pop & ~rxs_valid;
  assign ev_set[EVT_TXS_UNDER] = rd_acc & hit_txs_pop & ~txs_valid;

  hfpa_w1c_bank #(.N(EVT_N)) u_events (
    .clk(clk), .reset(sreset), .set(ev_set), .clr_wr(ev_clr_wr),
    .clr_data(host_wdata[EVT_N-1:0]), .bits(events)
  );

  wire rxd_full_now = (rxd_level >= rxd_cap) || (rxd_level >= CNT_W'(FIFO_DEPTH));
  wire txd_room_now = (txd_level < txd_cap) && (txd_level < CNT_W'(FIFO_DEPTH));
  wire next_lat_full = (lat_full & ~latch_rd) | rxd_full_now;
  wire next_lat_room = (lat_room | latch_rd) & txd_room_now;
  wire drop_inc = refused & (drop != DROP_MAX);
  wire [DROP_W-1:0] next_drop = drop_rd ? DROP_W'(refused) : drop + DROP_W'(drop_inc);

  always_ff @(posedge clk) begin
    if (sreset) begin
      lat_full <= 1'b0;
      lat_room <= 1'b1;
      drop <= DROP_RESET;
    end else begin
      lat_full <= next_lat_full;
      lat_room <= next_lat_room;
      drop <= next_drop;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      keep <= KEEP_RESET;
    end else if (keep_wr) begin
      keep <= host_wdata[KEEP_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] hfpa_half(input logic [DATA_W-1:0] w, input logic hi);
    hfpa_half = hi ? {{HALF_W{1'b0}}, w[DATA_W-1:HALF_W]} : {{HALF_W{1'b0}}, w[HALF_W-1:0]};
  endfunction : hfpa_half

  wire [DATA_W-1:0] rxd_word = rxd_valid ? rxd_data : '0;
  wire [DATA_W-1:0] rxs_word = rxs_valid ? rxs_data : '0;
  wire [DATA_W-1:0] txs_word = txs_valid ? txs_data : '0;
  wire [DATA_W-1:0] rxd_view = mode16 ? hfpa_half(rxd_word, rxd_half) : rxd_word;
  wire [DATA_W-1:0] rxs_view = mode16 ? hfpa_half(rxs_word, host_addr[1]) : rxs_word;
  wire [DATA_W-1:0] txs_view = mode16 ? hfpa_half(txs_word, host_addr[1]) : txs_word;
  wire [DATA_W-1:0] status_word = DATA_W'({mode16, 1'b0, txd_level, 1'b0, txs_level,
                                           1'b0, rxd_level, 1'b0, rxs_level});
  wire [DATA_W-1:0] ctrl_word = DATA_W'({1'b0, txd_cap, 1'b0, rxs_cap, 1'b0, rxd_cap,
                                         5'h00, 1'b0, tx_flush, rx_flush});
  wire [DATA_W-1:0] latch_word = DATA_W'({lat_room, lat_full});
  wire [DATA_W-1:0] next_rdata =
    in_rxd ? rxd_view :
    in_txd ? '0 :
    (hit_rxs_pop | hit_rxs_peek) ? rxs_view :
    (hit_txs_pop | hit_txs_peek) ? txs_view :
    (word_addr == ADDR_STATUS) ? status_word :
    (word_addr == ADDR_CTRL) ? ctrl_word :
    (word_addr == ADDR_EVENT) ? DATA_W'(events) :
    (word_addr == ADDR_LATCH) ? latch_word :
    (word_addr == ADDR_DROP) ? DATA_W'(drop) :
    (word_addr == ADDR_KEEP) ? DATA_W'(keep) : '0;

  always_ff @(posedge clk) begin
    if (reset) begin
      host_rdata <= '0;
      host_rvalid <= 1'b0;
    end else begin
      host_rdata <= rd_acc ? next_rdata : host_rdata;
      host_rvalid <= rd_acc;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire rx_quiet = !sreset && !rx_flush;
  wire tx_quiet = !sreset && !tx_flush;

  property p_ro_drop;
    wr_acc && (word_addr == ADDR_DROP) && !refused && !soft_rst |=> drop == $past(drop);
  endproperty
  a_ro_drop: assert property (p_ro_drop) else $error("drop count changed by write");
  property p_wo_zero;
    rd_acc && in_txd |=> host_rvalid && (host_rdata == '0);
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("tx data port read not zero");
  property p_w1c;
    ev_clr_wr && host_wdata[EVT_RXD_UNDER] && !ev_set[EVT_RXD_UNDER] && !soft_rst
      |=> !events[EVT_RXD_UNDER];
  endproperty
  a_w1c: assert property (p_w1c) else $error("event bit not cleared by one");
  property p_rc;
    drop_rd && !refused && !soft_rst |=> host_rdata == DATA_W'($past(drop)) && drop == '0;
  endproperty
  a_rc: assert property (p_rc) else $error("clear on read failed");
  property p_latch;
    lat_full && !latch_rd && !soft_rst |=> lat_full;
  endproperty
  a_latch: assert property (p_latch) else $error("latched bit lost before read");
  property p_soft_reset_immune;
    soft_rst && !keep_wr |=> keep == $past(keep);
  endproperty
  a_soft_reset_immune: assert property (p_soft_reset_immune) else $error("immune word lost on soft reset");
  property p_defaults;
    soft_rst |=> rxd_cap == CAP_RESET && txd_cap == CAP_RESET && rxd_level == '0 && !soft_rst;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not loaded");
  property p_rxs_pop;
    rxs_pop && !rxs_push && rx_quiet |=> rxs_level == CNT_W'($past(rxs_level) - 1'b1);
  endproperty
  a_rxs_pop: assert property (p_rxs_pop) else $error("rx status pop missed");
  property p_rxs_peek;
    rd_acc && hit_rxs_peek && !rxs_push && rx_quiet |=> $stable(rxs_level);
  endproperty
  a_rxs_peek: assert property (p_rxs_peek) else $error("rx status peek popped");
  property p_rxd_pop;
    rxd_rd && !mode16 && rxd_valid && !rxd_push && rx_quiet
      |=> rxd_level == CNT_W'($past(rxd_level) - 1'b1);
  endproperty
  a_rxd_pop: assert property (p_rxd_pop) else $error("rx data read did not pop");
  property p_txs_pop;
    txs_pop && !txs_push && tx_quiet |=> txs_level == CNT_W'($past(txs_level) - 1'b1);
  endproperty
  a_txs_pop: assert property (p_txs_pop) else $error("tx status pop missed");
  property p_txs_peek;
    rd_acc && hit_txs_peek && !txs_push && tx_quiet |=> $stable(txs_level);
  endproperty
  a_txs_peek: assert property (p_txs_peek) else $error("tx status peek popped");
  property p_txd_push;
    txd_push && txd_ready && !txd_drain && tx_quiet
      |=> txd_level == CNT_W'($past(txd_level) + 1'b1);
  endproperty
  a_txd_push: assert property (p_txd_push) else $error("tx data write not pushed");
  property p_rx_ro;
    wr_acc && (in_rxd || hit_rxs_pop) && !rxd_push && !rxs_push && rx_quiet
      |=> $stable(rxd_level) && $stable(rxs_level);
  endproperty
  a_rx_ro: assert property (p_rx_ro) else $error("write altered rx fifo");
  property p_sc;
    ctrl_wr && host_wdata[CTRL_RX_FLUSH] && !sreset |=> rx_flush ##1 !rx_flush;
  endproperty
  a_sc: assert property (p_sc) else $error("flush bit did not self clear");

  c_rx_pop: cover property (rxs_pop ##1 rxd_pop);
  c_tx_full: cover property (txd_push ##1 !txd_ready);
  c_soft: cover property (ctrl_wr && host_wdata[CTRL_SOFT_RST] ##1 soft_rst);
  c_half: cover property (mode16 && txd_push && txd_ready);
endmodule : hfpa_host_port

//--- tb/hfpa_net_model.sv
module hfpa_net_model import hfpa_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic fill,
  input wire logic stall,
  output logic [DATA_W-1:0] rx_stat_in,
  output logic rx_stat_in_valid,
  input wire logic rx_stat_in_ready,
  output logic [DATA_W-1:0] rx_data_in,
  output logic rx_data_in_valid,
  input wire logic rx_data_in_ready,
  output logic [DATA_W-1:0] tx_stat_in,
  output logic tx_stat_in_valid,
  input wire logic tx_stat_in_ready,
  output logic tx_data_out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Offers four words per stream, garbage while idle
  // ----------------------------------------------------------------
  logic [2:0] n [3];
  logic tick;
  logic [2:0] v;
  logic [2:0] r;
  logic [DATA_W-1:0] d [3];
  assign r = {tx_stat_in_ready, rx_data_in_ready, rx_stat_in_ready};
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      v[i] = fill && n[i] < 3'h4;
      d[i] = (32'h1000_0000 * (i + 1)) + 32'(n[i]);
      if (!v[i]) begin
        d[i] = ~d[i] ^ {32{tick}};
      end
    end
  end
  assign {tx_stat_in_valid, rx_data_in_valid, rx_stat_in_valid} = v;
  assign rx_stat_in = d[0];
  assign rx_data_in = d[1];
  assign tx_stat_in = d[2];
  // Slow sink: takes a word every other cycle unless stalled
  assign tx_data_out_ready = !stall && tick;
  always @(posedge clk) begin
    tick <= reset ? 1'b0 : ~tick;
    for (int i = 0; i < 3; i++) begin
      if (reset) begin
        n[i] <= 3'h0;
      end else if (v[i] && r[i]) begin
        n[i] <= n[i] + 3'h1;
      end
    end
  end
endmodule : hfpa_net_model

//--- tb/hfpa_host_port_tb.sv
module hfpa_host_port_tb import hfpa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, cs = 0, rd = 0, wr = 0, fill = 0, stall = 1, m16 = 0;
  logic [7:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic [DATA_W-1:0] host_rdata, tx_data_out, rxs, rxd, txs, w, keep;
  logic host_rvalid, rxs_v, rxs_r, rxd_v, rxd_r, txs_v, txs_r, txd_v, txd_r;
  integer errors = 0, checks_done = 0, seed = 32'h0387_8aae;
  logic [DATA_W-1:0] rd_q [$];
  logic [DATA_W-1:0] tx_q [$];
  always #50 clk = ~clk;
  hfpa_host_port dut_u (.clk(clk), .reset(reset), .bus_mode16_strap(m16), .host_cs(cs),
    .host_rd(rd), .host_wr(wr), .host_addr(addr), .host_wdata(wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .rx_stat_in(rxs), .rx_stat_in_valid(rxs_v),
    .rx_stat_in_ready(rxs_r), .rx_data_in(rxd), .rx_data_in_valid(rxd_v),
    .rx_data_in_ready(rxd_r), .tx_stat_in(txs), .tx_stat_in_valid(txs_v),
    .tx_stat_in_ready(txs_r), .tx_data_out(tx_data_out), .tx_data_out_valid(txd_v),
    .tx_data_out_ready(txd_r));
  hfpa_net_model mdl_u (.clk(clk), .reset(reset), .fill(fill), .stall(stall),
    .rx_stat_in(rxs), .rx_stat_in_valid(rxs_v), .rx_stat_in_ready(rxs_r), .rx_data_in(rxd),
    .rx_data_in_valid(rxd_v), .rx_data_in_ready(rxd_r), .tx_stat_in(txs),
    .tx_stat_in_valid(txs_v), .tx_stat_in_ready(txs_r), .tx_data_out_ready(txd_r));
  // ----------------------------------------------------------------
  // Bus tasks and compares
  // ----------------------------------------------------------------
  task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_rd(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    cmp(g, e);
  endtask : cmp_rd
  task automatic cmp_tx(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    cmp(g, e);
  endtask : cmp_tx
  // Only mapped registers are written
  task automatic acc(input logic r, input logic [7:0] a, input logic [DATA_W-1:0] d);
    cs = 1;
    rd = r;
    wr = !r;
    addr = a;
    wdata = d;
    @(negedge clk);
  endtask : acc
  task automatic rdx(input logic [7:0] a, input logic [DATA_W-1:0] e);
    rd_q.push_back(e);
    acc(1'b1, a, 32'h0000_0000);
  endtask : rdx
  task automatic idle(input int n);
    cs = 0;
    rd = 0;
    wr = 0;
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  always @(negedge clk) if (host_rvalid === 1'b1) cmp_rd(host_rdata, rd_q.pop_front());
  always @(posedge clk) if (txd_v === 1'b1 && txd_r === 1'b1) cmp_tx(tx_data_out, tx_q.pop_front());
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    reset = 0;
    rdx(ADDR_STATUS, 32'h0000_0000);
    rdx(ADDR_CTRL, 32'h0004_4400);
    rdx(ADDR_LATCH, 32'h0000_0002);
    rdx(ADDR_DROP, 32'h0000_0000);
    rdx(ADDR_KEEP, 32'h0000_0000);
    rdx(ADDR_RX_DATA + 8'h0c, 32'h0000_0000);
    rdx(ADDR_RX_STAT_POP, 32'h0000_0000);
    rdx(ADDR_TX_STAT_POP, 32'h0000_0000);
    rdx(ADDR_TX_DATA + 8'h10, 32'h0000_0000);
    rdx(ADDR_EVENT, 32'h0000_000d);
    acc(1'b0, ADDR_EVENT, 32'h0000_0002);
    rdx(ADDR_EVENT, 32'h0000_000d);
    acc(1'b0, ADDR_EVENT, 32'h0000_000d);
    rdx(ADDR_EVENT, 32'h0000_0000);
    fill = 1;
    idle(8);
    acc(1'b0, ADDR_STATUS, 32'h0000_0000);
    acc(1'b0, ADDR_RX_DATA, 32'h0000_0000);
    acc(1'b0, ADDR_RX_STAT_POP, 32'h0000_0000);
    rdx(ADDR_STATUS, 32'h0000_0444);
    rdx(ADDR_LATCH, 32'h0000_0003);
    rdx(ADDR_RX_DATA + 8'h04, 32'h2000_0000);
    idle(3);
    rdx(ADDR_LATCH, 32'h0000_0003);
    idle(3);
    rdx(ADDR_LATCH, 32'h0000_0002);
    rdx(ADDR_RX_STAT_PEEK, 32'h1000_0000);
    rdx(ADDR_RX_STAT_PEEK, 32'h1000_0000);
    rdx(ADDR_RX_STAT_POP, 32'h1000_0000);
    rdx(ADDR_RX_STAT_POP, 32'h1000_0001);
    rdx(ADDR_RX_STAT_PEEK, 32'h1000_0002);
    rdx(ADDR_TX_STAT_PEEK, 32'h3000_0000);
    rdx(ADDR_TX_STAT_POP, 32'h3000_0000);
    rdx(ADDR_TX_STAT_PEEK, 32'h3000_0001);
    rdx(ADDR_TX_STAT_POP, 32'h3000_0001);
    rdx(ADDR_RX_DATA + 8'h1c, 32'h2000_0001);
    rdx(ADDR_RX_DATA + 8'h08, 32'h2000_0002);
    rdx(ADDR_RX_DATA + 8'h14, 32'h2000_0003);
    for (int i = 0; i < 5; i++) begin
      w = $random(seed);
      if (i < 4) tx_q.push_back(w);
      acc(1'b0, ADDR_TX_DATA + 8'((i * 7) % 8 * 4), w);
    end
    idle(2);
    rdx(ADDR_TX_DATA + 8'h08, 32'h0000_0000);
    rdx(ADDR_EVENT, 32'h0000_0002);
    rdx(ADDR_LATCH, 32'h0000_0000);
    stall = 0;
    idle(20);
    cmp_tx(32'(tx_q.size()), 32'h0000_0000);
    keep = {16'h0000, 16'($random(seed))};
    acc(1'b0, ADDR_KEEP, keep);
    acc(1'b0, ADDR_CTRL, 32'h0004_4404);
    idle(4);
    rdx(ADDR_KEEP, keep);
    rdx(ADDR_CTRL, 32'h0004_4400);
    rdx(ADDR_STATUS, 32'h0000_0000);
    rdx(ADDR_LATCH, 32'h0000_0002);
    rdx(ADDR_EVENT, 32'h0000_0000);
    idle(4);
    m16 = 1;
    reset = 1;
    idle(4);
    reset = 0;
    idle(6);
    acc(1'b0, ADDR_DROP, 32'h0000_00ff);
    rdx(ADDR_DROP, 32'h0000_0001);
    rdx(ADDR_DROP, 32'h0000_0000);
    rdx(ADDR_RX_DATA + 8'h02, 32'h0000_0000);
    rdx(ADDR_RX_DATA + 8'h1e, 32'h0000_2000);
    rdx(ADDR_RX_DATA + 8'h04, 32'h0000_0001);
    rdx(ADDR_RX_STAT_PEEK + 8'h02, 32'h0000_1000);
    rdx(ADDR_RX_STAT_POP, 32'h0000_0000);
    rdx(ADDR_RX_STAT_POP + 8'h02, 32'h0000_1000);
    rdx(ADDR_RX_STAT_POP, 32'h0000_0001);
    w = $random(seed);
    tx_q.push_back(w);
    acc(1'b0, ADDR_TX_DATA + 8'h06, {16'h0000, w[15:0]});
    acc(1'b0, ADDR_TX_DATA + 8'h1a, {16'h0000, w[31:16]});
    idle(6);
    rdx(ADDR_STATUS, 32'h0001_0433);
    acc(1'b0, ADDR_CTRL, 32'h0004_4403);
    idle(2);
    rdx(ADDR_STATUS, 32'h0001_0000);
    rdx(ADDR_CTRL, 32'h0004_4400);
    cmp_tx(32'(tx_q.size()), 32'h0000_0000);
    idle(4);
    complete_run();
  end
endmodule : hfpa_host_port_tb
